// ### design/dyn_bus_sizer.sv
// bus cycle sequencer that splits operands by acknowledged port width
`timescale 1ns/100ps
`include "dbs_map.svh"
module dyn_bus_sizer
	import dbs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        req_valid_i,
	input  wire logic        req_fetch_i,
	input  wire logic        req_write_i,
	input  wire logic [1:0]  req_len_i,
	input  wire logic [31:0] req_addr_i,
	input  wire logic [31:0] req_wdata_i,
	input  wire logic        cache_en_i,
	input  wire logic        port_width_ack_hi_i,
	input  wire logic        port_width_ack_lo_i,
	input  wire logic [31:0] bus_data_i,
	output logic             req_ready_o,
	output logic             done_o,
	output logic      [31:0] rdata_o,
	output logic      [2:0]  cycles_o,
	output logic      [31:0] bus_addr_o,
	output logic             xfer_len_hi_o,
	output logic             xfer_len_lo_o,
	output logic             bus_write_o,
	output logic             bus_cycle_o,
	output logic             data_valid_strobe_o,
	output logic      [31:0] bus_data_o,
	output logic             bus_data_oe_o,
	output logic      [31:0] hold_word_o,
	output logic      [15:0] fetch_word_o,
	output logic             cache_fill_o
);
	seq_state_t  st_q,    st_d;
	logic [31:0] addr_q,  addr_d;
	logic [2:0]  left_q,  left_d;
	logic [31:0] wr_q,    wr_d;
	logic [31:0] rd_q,    rd_d;
	logic        wrt_q,   wrt_d;
	logic        fet_q,   fet_d;
	logic        wsel_q,  wsel_d;
	logic [2:0]  cyc_q,   cyc_d;
	logic        stb_q,   stb_d;
	logic        oe_q,    oe_d;
	logic        done_q,  done_d;
	logic        fill_q,  fill_d;
	logic        rdy_q,   rdy_d;
	logic [31:0] hold_q,  hold_d;
	logic [15:0] fw_q,    fw_d;
	logic [31:0] bdat_q,  bdat_d;
	logic [2:0]  pw;
	logic [2:0]  off;
	logic [2:0]  room;
	logic [2:0]  cnt;
	logic [31:0] rd_new;

	// acknowledge pair names the port width; none means keep waiting
	always_comb begin
		case ({port_width_ack_hi_i, port_width_ack_lo_i})
			`ACK_L:  pw = `BYTES_L;
			`ACK_W:  pw = `BYTES_W;
			`ACK_B:  pw = `BYTES_B;
			default: pw = `BYTES_NONE;
		endcase
	end

	// offset inside the port and the bytes the port can take now
	assign off  = (pw == `BYTES_L) ? {1'b0, addr_q[1:0]} :
		(pw == `BYTES_W) ? {2'h0, addr_q[0]} : `BYTES_NONE;
	assign room = pw - off;
	assign cnt  = (left_q < room) ? left_q : room;

	// read capture: operand is right-justified, first byte most significant
	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_rd
			logic [2:0] idx;
			logic [1:0] lane;
			logic       pick;
			assign idx  = left_q - 3'(p) - `BYTES_B;
			assign lane = 2'(off + idx);
			assign pick = (3'(p) < left_q) && (idx < cnt);
			assign rd_new[8*p +: 8] = pick ?
				bus_data_i[8*(`LAST_LANE - lane) +: 8] : rd_q[8*p +: 8];
		end
	endgenerate

	lane_mux u_lane_mux (
		.addr_lo_i (addr_d[1:0]),
		.left_i    (left_d),
		.data_i    (wr_d),
		.lanes_o   (bdat_d)
	);

	always_comb begin
		st_d   = st_q;
		addr_d = addr_q;
		left_d = left_q;
		wr_d   = wr_q;
		rd_d   = rd_q;
		wrt_d  = wrt_q;
		fet_d  = fet_q;
		wsel_d = wsel_q;
		cyc_d  = cyc_q;
		hold_d = hold_q;
		fw_d   = fw_q;
		stb_d  = 1'b0;
		oe_d   = 1'b0;
		done_d = 1'b0;
		fill_d = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (req_valid_i) begin
					fet_d  = req_fetch_i;
					wrt_d  = req_write_i && !req_fetch_i;
					wsel_d = req_addr_i[1];
					// prefetch always takes the aligned long word
					addr_d = req_fetch_i ?
						{req_addr_i[31:2], `LONG_ALIGN} : req_addr_i;
					left_d = (req_fetch_i || req_len_i == `LEN_FOUR) ?
						`BYTES_L : {1'b0, req_len_i};
					wr_d   = req_wdata_i;
					rd_d   = '0;
					cyc_d  = '0;
					stb_d  = 1'b1;
					oe_d   = wrt_d;
					st_d   = ST_BUS;
				end
			end
			ST_BUS: begin
				stb_d = 1'b1;
				oe_d  = wrt_q;
				if (pw != `BYTES_NONE) begin
					rd_d   = rd_new;
					addr_d = addr_q + 32'(cnt);
					left_d = left_q - cnt;
					cyc_d  = cyc_q + 3'h1;
					stb_d  = 1'b0;
					oe_d   = 1'b0;
					if (left_d == `BYTES_NONE) begin
						done_d = 1'b1;
						st_d   = ST_IDLE;
						if (fet_q) begin
							// kept even when the cache is off
							hold_d = rd_new;
							fw_d   = wsel_q ? rd_new[15:0] : rd_new[31:16];
							fill_d = cache_en_i;
						end
					end else begin
						st_d = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				// strobes drop for one cycle between split cycles
				stb_d = 1'b1;
				oe_d  = wrt_q;
				st_d  = ST_BUS;
			end
			default: st_d = ST_IDLE;
		endcase
		rdy_d = (st_d == ST_IDLE);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q   <= ST_IDLE;
			addr_q <= '0;
			left_q <= '0;
			wr_q   <= '0;
			rd_q   <= '0;
			wrt_q  <= 1'b0;
			fet_q  <= 1'b0;
			wsel_q <= 1'b0;
			cyc_q  <= '0;
			stb_q  <= 1'b0;
			oe_q   <= 1'b0;
			done_q <= 1'b0;
			fill_q <= 1'b0;
			rdy_q  <= 1'b1;
			hold_q <= '0;
			fw_q   <= '0;
			bdat_q <= '0;
		end else begin
			st_q   <= st_d;
			addr_q <= addr_d;
			left_q <= left_d;
			wr_q   <= wr_d;
			rd_q   <= rd_d;
			wrt_q  <= wrt_d;
			fet_q  <= fet_d;
			wsel_q <= wsel_d;
			cyc_q  <= cyc_d;
			stb_q  <= stb_d;
			oe_q   <= oe_d;
			done_q <= done_d;
			fill_q <= fill_d;
			rdy_q  <= rdy_d;
			hold_q <= hold_d;
			fw_q   <= fw_d;
			bdat_q <= bdat_d;
		end
	end

	assign req_ready_o         = rdy_q;
	assign done_o              = done_q;
	assign rdata_o             = rd_q;
	assign cycles_o            = cyc_q;
	assign bus_addr_o          = addr_q;
	assign xfer_len_hi_o       = left_q[1];
	assign xfer_len_lo_o       = left_q[0];
	assign bus_write_o         = wrt_q;
	assign bus_cycle_o         = stb_q;
	assign data_valid_strobe_o = stb_q;
	assign bus_data_o          = bdat_q;
	assign bus_data_oe_o       = oe_q;
	assign hold_word_o         = hold_q;
	assign fetch_word_o        = fw_q;
	assign cache_fill_o        = fill_q;

	// checking helpers: first request shape and first acknowledged width
	logic [2:0] h_len_q;
	logic [1:0] h_off_q;
	logic [2:0] h_pw_q;
	logic       h_mix_q;
	logic       h_first_q;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			h_len_q   <= '0;
			h_off_q   <= '0;
			h_pw_q    <= '0;
			h_mix_q   <= 1'b0;
			h_first_q <= 1'b0;
		end else if (st_q == ST_IDLE && req_valid_i) begin
			h_len_q   <= left_d;
			h_off_q   <= addr_d[1:0];
			h_mix_q   <= 1'b0;
			h_first_q <= 1'b1;
		end else if (st_q == ST_BUS && pw != `BYTES_NONE) begin
			h_first_q <= 1'b0;
			if (h_first_q)
				h_pw_q <= pw;
			else if (pw != h_pw_q)
				h_mix_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_byte_single: assert property (
		done_o && h_len_q == 3'h1 |-> cycles_o == 3'h1)
		else $error("byte operand took more than one cycle");
	a_word_odd3: assert property (
		done_o && h_len_q == 3'h2 && h_off_q == 2'h3 && !h_mix_q
		|-> cycles_o == 3'h2)
		else $error("word at offset 3 not two cycles");
	a_long_count: assert property (
		done_o && h_len_q == 3'h4 && h_off_q == 2'h1 && !h_mix_q
		|-> cycles_o == ((h_pw_q == 3'h4) ? 3'h2 :
			(h_pw_q == 3'h2) ? 3'h3 : 3'h4))
		else $error("long word at offset 1 wrong cycle count");
	a_fetch_align: assert property (
		$rose(bus_cycle_o) && h_first_q && fet_q
		|-> bus_addr_o[1:0] == 2'h0 && {xfer_len_hi_o, xfer_len_lo_o} == 2'h0)
		else $error("prefetch not long-word aligned");
	a_write_lanes: assert property (
		bus_cycle_o && bus_write_o |-> bus_data_oe_o)
		else $error("write cycle without data drive");
	a_three_bytes: assert property (
		st_q == ST_BUS && left_q == 3'h4 && addr_q[1:0] == 2'h1 &&
		pw == 3'h4 |=> left_q == 3'h1 && bus_addr_o[1:0] == 2'h0
		##1 bus_cycle_o)
		else $error("offset 01 long word not split 3 then 1");
	a_resume_addr: assert property (
		st_q == ST_BUS && pw != 3'h0 && cnt < left_q
		|=> bus_addr_o == $past(bus_addr_o) + 32'($past(cnt)) && !bus_cycle_o
		##1 bus_cycle_o)
		else $error("split cycle did not resume at advanced address");
	a_hold_fetch: assert property (
		done_o && fet_q |-> hold_word_o == rdata_o)
		else $error("holding register missed fetched word");
	a_cache_fill: assert property (
		st_q == ST_BUS && pw != 3'h0 && cnt == left_q && fet_q && cache_en_i
		|=> cache_fill_o && done_o)
		else $error("cached fetch did not fill");
	a_len_range: assert property (
		bus_cycle_o |-> left_q != 3'h0 && left_q <= 3'h4 ##0
		!done_o)
		else $error("bus cycle with nothing left to move");

	c_long_odd_word: cover property (
		done_o && h_len_q == 3'h4 && h_off_q == 2'h1 && h_pw_q == 3'h2);
	c_fetch_byte: cover property (done_o && fet_q && cycles_o == 3'h4);
	c_write_split: cover property (done_o && wrt_q && cycles_o == 3'h2);
endmodule : dyn_bus_sizer

// ### design/dbs_map.svh
// constants for the dynamic bus sizing block
// How it works
// - cycle count follows operand size, byte offset and acknowledged port width
// - a byte operand always finishes in one bus cycle
// - word cycles 32/16/8: offset 0,2 1/1/2; offset 1 1/2/2; offset 3 2/2/2
// - long cycles 32/16/8: offset 0 1/2/4; offsets 1,3 2/3/4; offset 2 2/2/4
// - prefetch asks a long word at offset 00; 1/2/4 cycles by port
// - odd-word fetch still reads the whole aligned word and may fill cache
// - the fetched word is always kept in a holding register
// - write cycles drive all four lanes since port width is unknown
// - each cycle moves the most bytes the port accepts at that offset
// - four bytes at offset 01: three on 32-bit port, one otherwise
// - long word at last lane on 32-bit port: one byte, then three at next boundary
// - after a partial cycle, restart with remaining size and advanced address
`ifndef DBS_MAP_SVH
`define DBS_MAP_SVH
`define LEN_FOUR    2'h0
`define LONG_ALIGN  2'h0
`define BYTES_L     3'h4
`define BYTES_W     3'h2
`define BYTES_B     3'h1
`define BYTES_NONE  3'h0
`define ACK_L       2'h3
`define ACK_W       2'h2
`define ACK_B       2'h1
`define LAST_LANE   2'h3
`endif

// ### design/dbs_pkg.sv
// types shared by the dynamic bus sizing block
package dbs_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BUS,
		ST_GAP
	} seq_state_t;
endpackage : dbs_pkg

// ### design/lane_mux.sv
// write data replication across the four byte lanes
`timescale 1ns/100ps
`include "dbs_map.svh"
module lane_mux (
	input  wire logic [1:0]  addr_lo_i,
	input  wire logic [2:0]  left_i,
	input  wire logic [31:0] data_i,
	output logic      [31:0] lanes_o
);
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_lane
			logic [1:0] idx;
			logic [1:0] sel;
			// lane k serves the 32-bit view when at or past the offset,
			// otherwise the 16- or 8-bit view of the same cycle
			assign idx = (2'(k) >= addr_lo_i) ? 2'(k) - addr_lo_i :
				((k == 2) || (k == 1 && !addr_lo_i[0])) ? 2'h1 : 2'h0;
			assign sel = 2'(left_i - 3'(idx) - `BYTES_B);
			// bytes beyond the operand are don't-care; send byte zero
			assign lanes_o[8*(3-k) +: 8] = ({1'b0, idx} < left_i) ?
				data_i[8*sel +: 8] : data_i[7:0];
		end
	endgenerate
endmodule : lane_mux

// ### sim/slave_port.sv
// memory slave of selectable width with wait states and byte enables
`timescale 1ns/100ps
module slave_port (
	input  wire logic        clk_i,
	input  wire logic [1:0]  pw_i,
	input  wire logic [1:0]  wait_i,
	input  wire logic        cyc_i,
	input  wire logic        strobe_i,
	input  wire logic        write_i,
	input  wire logic [1:0]  len_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	output logic             ack_hi_o,
	output logic             ack_lo_o,
	output logic      [31:0] rdata_o
);
	logic [7:0]  mem [64];
	logic [1:0]  cnt_q;
	logic [31:0] pat_q;
	logic [3:0]  en;
	logic [5:0]  base;
	logic        ack;
	int          n;
	initial begin
		for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h5a;
		cnt_q = 2'h0;
		pat_q = 32'h0;
	end
	always_comb begin
		n = (len_i == 2'h0) ? 4 : int'(len_i);
		base = addr_i[5:0] & ~((pw_i == 2'h3) ? 6'h3 : 6'(pw_i - 2'h1));
		for (int k = 0; k < 4; k++)
			en[k] = k >= int'(addr_i[1:0]) && k < int'(addr_i[1:0]) + n;
		if (pw_i == 2'h2) en = {2'b00, addr_i[0] || n > 1, !addr_i[0]};
		if (pw_i == 2'h1) en = 4'h1;
		en = {en[0], en[1], en[2], en[3]};
		ack = cyc_i && cnt_q == wait_i;
		ack_hi_o = ack && pw_i[1];
		ack_lo_o = ack && pw_i[0];
		// released or unselected lanes show a changing pattern, not old data
		for (int k = 0; k < 4; k++)
			rdata_o[24-8*k +: 8] = (ack && en[3-k] && !write_i) ?
				mem[base + 6'(k)] : pat_q[24-8*k +: 8];
	end
	always @(posedge clk_i) begin
		pat_q <= pat_q + 32'h9e3779b9;
		cnt_q <= (ack || !cyc_i) ? 2'h0 : cnt_q + 2'h1;
		for (int k = 0; k < 4; k++)
			if (ack && write_i && strobe_i && en[3-k])
				mem[base + 6'(k)] <= wdata_i[24-8*k +: 8];
	end
endmodule : slave_port

// ### sim/tb_dynamic_bus_sizing_byte_enables.sv
// self-checking bench for the dynamic bus sizing sequencer
`timescale 1ns/100ps
module tb_dynamic_bus_sizing_byte_enables;
	typedef struct {logic [2:0] cyc; logic [31:0] rd; logic isrd, ft;
		logic [15:0] fw; logic fill;} exp_t;
	logic        clk_i, sys_rst_i, req_valid_i, req_fetch_i, req_write_i;
	logic        cache_en_i, port_width_ack_hi_i, port_width_ack_lo_i;
	logic [1:0]  req_len_i, pw, wt;
	logic [31:0] req_addr_i, req_wdata_i, bus_data_i, rdata_o, bus_addr_o;
	logic [31:0] bus_data_o, hold_word_o;
	logic [15:0] fetch_word_o;
	logic [2:0]  cycles_o;
	logic        req_ready_o, done_o, xfer_len_hi_o, xfer_len_lo_o;
	logic        bus_write_o, bus_cycle_o, data_valid_strobe_o;
	logic        bus_data_oe_o, cache_fill_o;
	logic [7:0]  shadow [64];
	exp_t        q [$];
	exp_t        m;
	int          err_total = 0;
	int          compares = 0;
	dyn_bus_sizer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.req_valid_i(req_valid_i), .req_fetch_i(req_fetch_i),
		.req_write_i(req_write_i), .req_len_i(req_len_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
		.cache_en_i(cache_en_i),
		.port_width_ack_hi_i(port_width_ack_hi_i),
		.port_width_ack_lo_i(port_width_ack_lo_i),
		.bus_data_i(bus_data_i),
		.req_ready_o(req_ready_o), .done_o(done_o),
		.rdata_o(rdata_o), .cycles_o(cycles_o),
		.bus_addr_o(bus_addr_o),
		.xfer_len_hi_o(xfer_len_hi_o),
		.xfer_len_lo_o(xfer_len_lo_o),
		.bus_write_o(bus_write_o), .bus_cycle_o(bus_cycle_o),
		.data_valid_strobe_o(data_valid_strobe_o),
		.bus_data_o(bus_data_o),
		.bus_data_oe_o(bus_data_oe_o),
		.hold_word_o(hold_word_o),
		.fetch_word_o(fetch_word_o),
		.cache_fill_o(cache_fill_o));
	slave_port slv (.clk_i(clk_i), .pw_i(pw), .wait_i(wt),
		.cyc_i(bus_cycle_o), .strobe_i(data_valid_strobe_o),
		.write_i(bus_write_o), .len_i({xfer_len_hi_o, xfer_len_lo_o}),
		.addr_i(bus_addr_o), .wdata_i(bus_data_o),
		.ack_hi_o(port_width_ack_hi_i), .ack_lo_o(port_width_ack_lo_i),
		.rdata_o(bus_data_i));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	function automatic logic [2:0] ncyc(int n, int a, int pb);
		int c, k;
		c = 0;
		while (n > 0) begin
			k = pb - (a % pb);
			if (k > n) k = n;
			n -= k;
			a += k;
			c++;
		end
		return 3'(c);
	endfunction : ncyc
	task automatic chk_cyc(input logic [2:0] g, input logic [2:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected cycles at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_cyc
	task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected data at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_data
	// waits for idle before touching the slave width, so accesses stay whole
	task automatic acc(input int p, input logic f, input logic w,
		input logic [1:0] len, input logic [5:0] a, input logic [31:0] wd);
		exp_t e;
		int   n, al;
		for (int i = 0; i < 400 && req_ready_o !== 1'b1; i++) begin
			@(posedge clk_i);
			#2;
		end
		// a sequencer that never returns to idle is a failure
		if (req_ready_o !== 1'b1) err_total++;
		pw = 2'(p);
		wt = 2'($urandom % 3);
		cache_en_i = 1'($urandom);
		n = (len == 2'h0 || f) ? 4 : int'(len);
		al = f ? int'(a & 6'h3c) : int'(a);
		e.cyc = ncyc(n, al, (p == 3) ? 4 : p);
		e.rd = 32'h0;
		for (int i = 0; i < n; i++) begin
			if (w && !f) shadow[6'(al + i)] = wd[8*(n-1-i) +: 8];
			e.rd = {e.rd[23:0], shadow[6'(al + i)]};
		end
		e.isrd = !w || f;
		e.ft = f;
		e.fw = a[1] ? e.rd[15:0] : e.rd[31:16];
		e.fill = f && cache_en_i;
		q.push_back(e);
		req_valid_i = 1'b1;
		req_fetch_i = f;
		req_write_i = w;
		req_len_i = len;
		req_addr_i = {26'h0, a};
		req_wdata_i = wd;
		@(posedge clk_i);
		#2;
		req_valid_i = 1'b0;
	endtask : acc
	always @(negedge clk_i) begin
		if (bus_cycle_o === 1'b1 && bus_write_o === 1'b1)
			chk_data(32'(bus_data_oe_o), 32'h1);
		if (done_o === 1'b1 && q.size() == 0) begin
			err_total++;
			$display("unexpected done at %0t got %h exp %h", $time, 1, 0);
		end else if (done_o === 1'b1) begin
			m = q.pop_front();
			chk_cyc(cycles_o, m.cyc);
			if (m.isrd && !m.ft)
				chk_data(rdata_o, m.rd);
			if (m.ft) chk_data(hold_word_o, m.rd);
			if (m.ft) chk_data({16'h0, fetch_word_o}, {16'h0, m.fw});
			chk_data(32'(cache_fill_o), 32'(m.fill));
		end
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h84fd8445));
		for (int i = 0; i < 64; i++) shadow[i] = 8'(i) ^ 8'h5a;
		{sys_rst_i, req_valid_i, req_fetch_i, req_write_i} = 4'h8;
		{cache_en_i, req_len_i, pw, wt} = 7'h0c;
		req_addr_i = 32'h0;
		req_wdata_i = 32'h0;
		repeat (6) @(posedge clk_i);
		#2;
		sys_rst_i = 1'b0;
		for (int p = 1; p < 4; p++)
			for (int l = 0; l < 4; l++)
				for (int o = 0; o < 4; o++) begin
					acc(p, 1'b0, 1'b1, 2'(l), 6'(16 + 4*l + o), $urandom);
					acc(p, 1'b0, 1'b0, 2'(l), 6'(16 + 4*l + o), 32'h0);
					acc(p, 1'b0, 1'b0, 2'h0, 6'(16 + 4*l), 32'h0);
					acc(p, 1'b1, 1'b0, 2'h0, 6'(16 + 4*l + o), 32'h0);
				end
		for (int i = 0; i < 200 && q.size() > 0; i++) @(posedge clk_i);
		if (q.size() > 0) err_total++;
		end_of_test();
	end
	task automatic end_of_test;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test
endmodule : tb_dynamic_bus_sizing_byte_enables
